// ### lpm_cfg.svh
// constants of the low power mode controller: offsets, fields, reset values
// Operation
// - light sleep gates only the processor clock
// - any interrupt or wake event ends sleep
// - both select bits plus wait enter standby
// - standby cuts core power and fast oscillators
// - event lines, pin or watchdog leave standby
// - supply detector holds device in reset
// - voltage monitor edges interrupt once enabled
// - stop request becomes standby automatically
// - wake-up selects the internal fast oscillator
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH

// register byte offsets
`define LPM_OFF_CTRL      8'h00
`define LPM_OFF_STAT      8'h04
`define LPM_OFF_INT_STAT  8'h08
`define LPM_OFF_INT_CLR   8'h0c
`define LPM_OFF_INT_EN    8'h10
`define LPM_OFF_WAKE_MASK 8'h14

// control register fields
`define LPM_CTRL_W        8
`define LPM_CTRL_RST      8'h00
`define LPM_CTRL_PDN_DEEP 0
`define LPM_CTRL_DEEP     1
`define LPM_CTRL_MON_EN   2
`define LPM_CTRL_LVL_LO   3
`define LPM_CTRL_LVL_HI   5
`define LPM_CTRL_XFO_ON   6
`define LPM_CTRL_CLK_EXT  7

// interrupt status, clear and enable layout
`define LPM_INT_W         4
`define LPM_INT_RST       4'h0
`define LPM_INT_MON_FALL  0
`define LPM_INT_MON_RISE  1
`define LPM_INT_STBY_WAKE 2
`define LPM_INT_SLP_WAKE  3

// mode codes shown in the status register
`define LPM_MODE_RUN      2'h0
`define LPM_MODE_SLEEP    2'h1
`define LPM_MODE_STANDBY  2'h2

`endif

// ### lpm_pkg.sv
// types of the low power mode controller
package lpm_pkg;
   // power mode of the device
   typedef enum logic [1:0] {
      LPM_RUN,
      LPM_SLEEP,
      LPM_STANDBY
   } lpm_mode_t;
endpackage

// ### lpm_sync_if.sv
// synchronised asynchronous inputs handed from the sync bank to the controller
`timescale 1ns/1ps
`default_nettype none
interface lpm_sync_if #(parameter int EV_LINES = 18);
   logic [EV_LINES-1:0] ev;         // external event lines
   logic                vmon_below; // supply under monitor threshold
   logic                tmr;        // auto wakeup timer
   logic                ext_rst;    // external reset pin asserted
   logic                wdg_rst;    // watchdog reset
   logic                supply_low; // supply reset detector
   modport src (output ev, vmon_below, tmr, ext_rst, wdg_rst, supply_low);
   modport dst (input ev, vmon_below, tmr, ext_rst, wdg_rst, supply_low);
endinterface
`default_nettype wire

// ### lpm_sync.sv
// two-flop synchroniser bank for every asynchronous input of the controller
`timescale 1ns/1ps
`default_nettype none
module lpm_sync #(
   parameter int EV_LINES = 18
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic [EV_LINES+4:0] raw,
   lpm_sync_if.src                  sif
);
   logic [EV_LINES+4:0] stage1_reg; // first stage, read only by stage two
   logic [EV_LINES+4:0] stage2_reg; // settled copy

   // both stages clear to idle under reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= raw;
         stage2_reg <= stage1_reg;
      end
   end

   // unpack the settled vector
   assign sif.ev         = stage2_reg[EV_LINES-1:0];
   assign sif.vmon_below = stage2_reg[EV_LINES];
   assign sif.tmr        = stage2_reg[EV_LINES+1];
   assign sif.ext_rst    = stage2_reg[EV_LINES+2];
   assign sif.wdg_rst    = stage2_reg[EV_LINES+3];
   assign sif.supply_low = stage2_reg[EV_LINES+4];
endmodule
`default_nettype wire

// ### lpm_ctrl.sv
// low power mode controller: sleep and standby sequencing, supply reset, monitor
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
module lpm_ctrl
   import lpm_pkg::*;
#(
   parameter int EV_LINES = 18
) (
   input  wire logic                REF_CLK,
   input  wire logic                SYS_RST,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [7:0]          PADDR,
   input  wire logic [31:0]         PWDATA,
   output var  logic [31:0]         PRDATA,
   output var  logic                PREADY,
   output var  logic                PSLVERR,
   input  wire logic                CPU_WFI,
   input  wire logic                CPU_WAIT_EV,
   input  wire logic                IRQ_PENDING,
   input  wire logic [EV_LINES-1:0] EV_LINES_IN,
   input  wire logic                VMON_BELOW,
   input  wire logic                TMR_WAKE,
   input  wire logic                EXT_RESET_PIN_N,
   input  wire logic                WDG_RESET,
   input  wire logic                SUPPLY_LOW,
   output var  logic                CPU_CLK_EN,
   output var  logic                PERIPH_CLK_EN,
   output var  logic                CORE_PWR_EN,
   output var  logic                IFO_EN,
   output var  logic                XFO_EN,
   output var  logic                SYSCLK_EXT,
   output var  logic                SYSTEM_RESET,
   output var  logic                VMON_ON,
   output var  logic [2:0]          VMON_LEVEL,
   output var  logic                IRQ
);
   localparam int MW = EV_LINES + 2; // wake mask: lines, monitor, timer

   ////////////////////////////////////////////////////////////////////////
   // synchronisers
   lpm_sync_if #(.EV_LINES(EV_LINES)) sif ();

   // every pin and foreign-clock input settles before use
   lpm_sync #(
      .EV_LINES (EV_LINES)
   ) lpm_sync_i (
      .clk (REF_CLK),
      .rst (SYS_RST),
      .raw ({SUPPLY_LOW, WDG_RESET, ~EXT_RESET_PIN_N, TMR_WAKE, VMON_BELOW, EV_LINES_IN}),
      .sif (sif.src)
   );

   ////////////////////////////////////////////////////////////////////////
   // state and registers
   lpm_mode_t                 state_reg;      // current power mode
   lpm_mode_t                 state_next;
   logic [`LPM_CTRL_W-1:0]    ctrl_reg;       // software control
   logic [`LPM_CTRL_W-1:0]    ctrl_next;
   logic [`LPM_INT_W-1:0]     int_stat_reg;   // sticky events
   logic [`LPM_INT_W-1:0]     int_stat_next;
   logic [`LPM_INT_W-1:0]     int_en_reg;     // interrupt enables
   logic [`LPM_INT_W-1:0]     int_en_next;
   logic [MW-1:0]             wake_mask_reg;  // standby wake sources
   logic [MW-1:0]             wake_mask_next;
   logic [EV_LINES-1:0]       ev_prev_reg;    // for edge detection
   logic                      tmr_prev_reg;
   logic                      mon_prev_reg;

   ////////////////////////////////////////////////////////////////////////
   // device reset sources
   wire dev_rst = sif.supply_low | sif.ext_rst | sif.wdg_rst;

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   wire        setup     = PSEL & ~PENABLE;
   wire        wr_en     = PSEL & PENABLE & PREADY & PWRITE;
   wire        sel_ctrl  = PADDR == `LPM_OFF_CTRL;
   wire        sel_stat  = PADDR == `LPM_OFF_STAT;
   wire        sel_istat = PADDR == `LPM_OFF_INT_STAT;
   wire        sel_iclr  = PADDR == `LPM_OFF_INT_CLR;
   wire        sel_ien   = PADDR == `LPM_OFF_INT_EN;
   wire        sel_wmask = PADDR == `LPM_OFF_WAKE_MASK;
   wire        unmapped  = ~(sel_ctrl | sel_stat | sel_istat | sel_iclr | sel_ien | sel_wmask);

   // mode code for the status register
   wire [1:0]  mode_code = (state_reg == LPM_RUN)   ? `LPM_MODE_RUN   :
                           (state_reg == LPM_SLEEP) ? `LPM_MODE_SLEEP : `LPM_MODE_STANDBY;
   wire [31:0] stat_word = {25'h0, SYSTEM_RESET, SYSCLK_EXT, XFO_EN, IFO_EN, sif.vmon_below, mode_code};

   // read mux; the clear register reads as zero
   wire [31:0] rd_mux = sel_ctrl  ? {{(32-`LPM_CTRL_W){1'b0}}, ctrl_reg}    :
                        sel_stat  ? stat_word                              :
                        sel_istat ? {{(32-`LPM_INT_W){1'b0}}, int_stat_reg} :
                        sel_ien   ? {{(32-`LPM_INT_W){1'b0}}, int_en_reg}   :
                        sel_wmask ? {{(32-MW){1'b0}}, wake_mask_reg}        : 32'h0;

   ////////////////////////////////////////////////////////////////////////
   // voltage monitor and wake events
   wire mon_en   = ctrl_reg[`LPM_CTRL_MON_EN];
   // dormant until enabled, so no stale edge fires at switch-on
   wire mon_fall = mon_en & sif.vmon_below & ~mon_prev_reg;
   wire mon_rise = mon_en & ~sif.vmon_below & mon_prev_reg;
   wire [EV_LINES-1:0] ev_edge = sif.ev & ~ev_prev_reg;
   wire tmr_edge = sif.tmr & ~tmr_prev_reg;

   // any unmasked line, monitor edge or timer tick ends standby
   wire stby_wake = |(ev_edge & wake_mask_reg[EV_LINES-1:0])
                  | ((mon_fall | mon_rise) & wake_mask_reg[EV_LINES])
                  | (tmr_edge & wake_mask_reg[EV_LINES+1]);
   // sleep also ends on any interrupt of the core
   wire slp_wake  = IRQ_PENDING | stby_wake;
   wire wait_req  = CPU_WFI | CPU_WAIT_EV;
   wire deep_sel  = ctrl_reg[`LPM_CTRL_DEEP];

   ////////////////////////////////////////////////////////////////////////
   // mode sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         LPM_RUN: begin
            if (wait_req) begin
               // deep select with or without power-down select ends in standby
               if (deep_sel) state_next = LPM_STANDBY;
               else state_next = LPM_SLEEP;
            end
         end
         LPM_SLEEP: begin
            if (slp_wake) state_next = LPM_RUN;
         end
         LPM_STANDBY: begin
            if (stby_wake) state_next = LPM_RUN;
         end
         default: state_next = LPM_RUN;
      endcase
      // a device reset always returns to run
      if (dev_rst) state_next = LPM_RUN;
   end

   wire waking = (state_reg != LPM_RUN) & (state_next == LPM_RUN);

   ////////////////////////////////////////////////////////////////////////
   // register next values
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_en & sel_ctrl) ctrl_next = PWDATA[`LPM_CTRL_W-1:0];
      // hardware wins over a write here: the clock must be safe after wake
      if (waking) ctrl_next[`LPM_CTRL_CLK_EXT] = 1'b0;
      if (dev_rst) ctrl_next = `LPM_CTRL_RST;
   end

   // sticky status: a set in the clearing cycle survives
   always_comb begin
      int_stat_next = int_stat_reg;
      if (wr_en & sel_iclr) int_stat_next = int_stat_reg & ~PWDATA[`LPM_INT_W-1:0];
      if (mon_fall) int_stat_next[`LPM_INT_MON_FALL] = 1'b1;
      if (mon_rise) int_stat_next[`LPM_INT_MON_RISE] = 1'b1;
      if (waking & (state_reg == LPM_STANDBY)) int_stat_next[`LPM_INT_STBY_WAKE] = 1'b1;
      if (waking & (state_reg == LPM_SLEEP)) int_stat_next[`LPM_INT_SLP_WAKE] = 1'b1;
      if (dev_rst) int_stat_next = `LPM_INT_RST;
   end

   assign int_en_next    = dev_rst ? `LPM_INT_RST :
                           (wr_en & sel_ien) ? PWDATA[`LPM_INT_W-1:0] : int_en_reg;
   assign wake_mask_next = dev_rst ? {MW{1'b1}} :
                           (wr_en & sel_wmask) ? PWDATA[MW-1:0] : wake_mask_reg;

   ////////////////////////////////////////////////////////////////////////
   // state flops
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_reg     <= LPM_RUN;
         ctrl_reg      <= `LPM_CTRL_RST;
         int_stat_reg  <= `LPM_INT_RST;
         int_en_reg    <= `LPM_INT_RST;
         wake_mask_reg <= {MW{1'b1}};
      end else begin
         state_reg     <= state_next;
         ctrl_reg      <= ctrl_next;
         int_stat_reg  <= int_stat_next;
         int_en_reg    <= int_en_next;
         wake_mask_reg <= wake_mask_next;
      end
   end

   // edge history; monitor history tracks the input while disabled
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ev_prev_reg  <= '0;
         tmr_prev_reg <= 1'b0;
         mon_prev_reg <= 1'b0;
      end else begin
         ev_prev_reg  <= sif.ev;
         tmr_prev_reg <= sif.tmr;
         mon_prev_reg <= sif.vmon_below;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power and clock outputs, registered from next state
   wire run_n  = state_next == LPM_RUN;
   wire stby_n = state_next == LPM_STANDBY;

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         CPU_CLK_EN    <= 1'b1;
         PERIPH_CLK_EN <= 1'b1;
         CORE_PWR_EN   <= 1'b1;
         IFO_EN        <= 1'b1;
         XFO_EN        <= 1'b0;
         SYSCLK_EXT    <= 1'b0;
         SYSTEM_RESET  <= 1'b1;
         VMON_ON       <= 1'b0;
         VMON_LEVEL    <= 3'h0;
      end else begin
         CPU_CLK_EN    <= run_n;
         PERIPH_CLK_EN <= ~stby_n;
         CORE_PWR_EN   <= ~stby_n;
         IFO_EN        <= ~stby_n;
         XFO_EN        <= ~stby_n & ctrl_next[`LPM_CTRL_XFO_ON];
         SYSCLK_EXT    <= ~stby_n & ctrl_next[`LPM_CTRL_XFO_ON]
                          & ctrl_next[`LPM_CTRL_CLK_EXT];
         SYSTEM_RESET  <= dev_rst;
         VMON_ON       <= ctrl_next[`LPM_CTRL_MON_EN];
         VMON_LEVEL    <= ctrl_next[`LPM_CTRL_LVL_HI:`LPM_CTRL_LVL_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb answer and interrupt output
   // zero wait states: ready is raised for the access phase only
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0;
         IRQ     <= 1'b0;
      end else begin
         PREADY  <= setup;
         PSLVERR <= setup & unmapped;
         PRDATA  <= (setup & ~PWRITE) ? rd_mux : 32'h0;
         IRQ     <= |(int_stat_reg & int_en_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);

   sleep_gate_a: assert property (
      state_reg == LPM_SLEEP |-> !CPU_CLK_EN && PERIPH_CLK_EN && CORE_PWR_EN)
      else $error("sleep must gate only the processor clock");

   sleep_wake_a: assert property (
      state_reg == LPM_SLEEP && IRQ_PENDING |=> state_reg == LPM_RUN && CPU_CLK_EN)
      else $error("interrupt did not end sleep");

   standby_entry_a: assert property (
      state_reg == LPM_RUN && wait_req && deep_sel && ctrl_reg[`LPM_CTRL_PDN_DEEP] && !dev_rst
      |=> state_reg == LPM_STANDBY ##1 state_reg == LPM_STANDBY || $past(stby_wake) || $past(dev_rst))
      else $error("standby not entered after wait with both selects");

   standby_off_a: assert property (
      state_reg == LPM_STANDBY |-> !CORE_PWR_EN && !IFO_EN && !XFO_EN && !CPU_CLK_EN)
      else $error("power or oscillator left on in standby");

   standby_exit_a: assert property (
      state_reg == LPM_STANDBY && (stby_wake || dev_rst) |=> state_reg == LPM_RUN && CORE_PWR_EN)
      else $error("wake source did not end standby");

   supply_hold_a: assert property (
      sif.supply_low [*2] |-> SYSTEM_RESET && state_reg == LPM_RUN && ctrl_reg == `LPM_CTRL_RST)
      else $error("low supply did not hold reset");

   monitor_irq_a: assert property (
      mon_fall && int_en_reg[`LPM_INT_MON_FALL] && !dev_rst
      ##1 int_en_reg[`LPM_INT_MON_FALL] && !dev_rst |=> IRQ)
      else $error("monitor edge did not raise the interrupt");

   monitor_off_a: assert property (
      !mon_en |=> !$rose(int_stat_reg[`LPM_INT_MON_FALL]) && !$rose(int_stat_reg[`LPM_INT_MON_RISE]))
      else $error("monitor event while disabled");

   stop_standby_a: assert property (
      state_reg == LPM_RUN && wait_req && deep_sel && !ctrl_reg[`LPM_CTRL_PDN_DEEP] && !dev_rst
      |=> state_reg == LPM_STANDBY)
      else $error("stop request did not become standby");

   wake_osc_a: assert property (
      state_reg != LPM_RUN ##1 state_reg == LPM_RUN |-> !SYSCLK_EXT && IFO_EN)
      else $error("wake did not select the internal oscillator");

   light_sleep_a: assert property (
      state_reg == LPM_RUN && wait_req && !deep_sel && !dev_rst |=> state_reg == LPM_SLEEP)
      else $error("wait without deep select did not enter sleep");

   // main scenarios
   standby_trip_c: cover property (
      state_reg == LPM_STANDBY ##1 state_reg == LPM_RUN);
   sleep_trip_c: cover property (
      state_reg == LPM_SLEEP ##1 state_reg == LPM_RUN);
   monitor_fall_c: cover property (mon_fall ##2 IRQ);
   supply_reset_c: cover property ($rose(SYSTEM_RESET));
endmodule
`default_nettype wire

// ### lpm_core_model.sv
// processor core and wake source model driving the power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpm_core_model #(
   parameter int EV_LINES = 18
) (
   input  wire logic                clk,
   input  wire logic                cpu_clk_en,
   output var  logic                wfi,
   output var  logic                wait_ev,
   output var  logic                irq_pending,
   output var  logic [EV_LINES-1:0] ev_lines,
   output var  logic                tmr
);
   // every source idles low from time zero
   initial begin
      wfi = 1'b0;
      wait_ev = 1'b0;
      irq_pending = 1'b0;
      ev_lines = '0;
      tmr = 1'b0;
   end
   ////////////////////////////////////////////////////////////////
   // one-cycle wait instruction: wfi, or wait for event when use_event is set
   task automatic wait_instr(input logic use_event);
      @(posedge clk);
      wfi <= !use_event;
      wait_ev <= use_event;
      @(posedge clk);
      wfi <= 1'b0;
      wait_ev <= 1'b0;
   endtask
   // source held four cycles so the two-flop sync cannot miss it
   task automatic pulse_src(input int idx);
      @(posedge clk);
      if (idx < EV_LINES) begin
         ev_lines[idx] <= 1'b1;
      end else begin
         tmr <= 1'b1;
      end
      repeat (4) @(posedge clk);
      ev_lines <= '0;
      tmr <= 1'b0;
   endtask
   // interrupt becomes pending while the processor clock is stopped
   task automatic raise_irq;
      @(posedge clk);
      irq_pending <= 1'b1;
   endtask
   // pending interrupt is taken once the processor clock runs again
   always @(posedge clk) begin
      if (cpu_clk_en && irq_pending) begin
         irq_pending <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### low_power_mode_controller_test.sv
// self-checking bench of the low power mode controller with a core model
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_controller_test;
   localparam int EV_LINES = 18;
   // one register access and the answer it should give
   typedef struct {
      logic        wr;
      logic [7:0]  adr;
      logic [31:0] wdat;
      logic [31:0] exp;
      logic        err;
   } lpm_row_t;
   logic                ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, rd;
   logic                cpu_wfi, cpu_wait_ev, irq_pending, tmr_wake, irq;
   logic [EV_LINES-1:0] ev_lines_in;
   logic                vmon_below, ext_reset_pin_n, wdg_reset, supply_low;
   logic                cpu_clk_en, periph_clk_en, core_pwr_en, ifo_en, xfo_en;
   logic                sysclk_ext, system_reset, vmon_on;
   logic [2:0]          vmon_level;
   int                  miscompares = 0;
   int                  total_checks = 0;
   logic [31:0]         sb_ctrl [2] = '{32'hc3, 32'hc2}; // standby, then stop request
   // register table walked once after reset
   lpm_row_t rows [13] = '{
      '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'hfffff, 1'b0},
      '{1'b0, 8'h10, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h00, 32'hec, 32'h0, 1'b0},
      '{1'b0, 8'h00, 32'h0, 32'hec, 1'b0}, '{1'b1, 8'h04, 32'hff, 32'h0, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h38, 1'b0}, '{1'b1, 8'h10, 32'hf, 32'h0, 1'b0},
      '{1'b0, 8'h10, 32'h0, 32'hf, 1'b0}, '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b0},
      '{1'b1, 8'h18, 32'h5, 32'h0, 1'b1}, '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
      '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0}
   };
   ////////////////////////////////////////////////////////////////
   lpm_ctrl #(.EV_LINES(EV_LINES)) lpm_ctrl_i (
      .REF_CLK(ref_clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CPU_WFI(cpu_wfi), .CPU_WAIT_EV(cpu_wait_ev), .IRQ_PENDING(irq_pending), .EV_LINES_IN(ev_lines_in),
      .VMON_BELOW(vmon_below), .TMR_WAKE(tmr_wake), .EXT_RESET_PIN_N(ext_reset_pin_n),
      .WDG_RESET(wdg_reset), .SUPPLY_LOW(supply_low), .CPU_CLK_EN(cpu_clk_en),
      .PERIPH_CLK_EN(periph_clk_en), .CORE_PWR_EN(core_pwr_en), .IFO_EN(ifo_en), .XFO_EN(xfo_en),
      .SYSCLK_EXT(sysclk_ext), .SYSTEM_RESET(system_reset), .VMON_ON(vmon_on),
      .VMON_LEVEL(vmon_level), .IRQ(irq));
   lpm_core_model #(.EV_LINES(EV_LINES)) lpm_core_model_i (
      .clk(ref_clk), .cpu_clk_en(cpu_clk_en), .wfi(cpu_wfi), .wait_ev(cpu_wait_ev),
      .irq_pending(irq_pending), .ev_lines(ev_lines_in), .tmr(tmr_wake));
   // 40 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // case equality so an unknown never passes
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // output watched by the bounded waits
   function automatic logic pick(input int s);
      case (s)
         0: return cpu_clk_en;
         1: return core_pwr_en;
         default: return system_reset;
      endcase
   endfunction
   task automatic wait_on(input int s, input logic v);
      int n;
      n = 0;
      while (pick(s) !== v) begin
         @(posedge ref_clk);
         n++;
         if (n > 40) begin
            miscompares++;
            $display("unexpected at %0t: wait %0d got %h expected %h", $time, s, pick(s), v);
            complete_run();
         end
      end
   endtask
   // apb transfer: setup, then access held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         miscompares++;
         $display("unexpected at %0t: pready %h expected %h", $time, pready, 1'b1);
         complete_run();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      {psel, penable, pwrite, vmon_below, wdg_reset, supply_low} = 6'h0;
      ext_reset_pin_n = 1'b1;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (16) @(posedge ref_clk);
      chk({system_reset, cpu_clk_en, core_pwr_en}, 3'h7);
      sys_rst <= 1'b0;
      wait_on(2, 1'b0);
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].adr, rows[i].wdat);
         if (!rows[i].wr) begin
            chk(rd, rows[i].exp);
         end
         chk(er, rows[i].err);
      end
      chk({vmon_on, vmon_level}, 4'hd);
      // monitor edges, then the monitor switched off
      vmon_below <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rdchk(8'h08, 32'h1);
      chk(irq, 1'b1);
      apb(1'b1, 8'h0c, 32'h1);
      vmon_below <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rdchk(8'h08, 32'h2);
      apb(1'b1, 8'h00, 32'h40);
      apb(1'b1, 8'h0c, 32'hf);
      vmon_below <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rdchk(8'h08, 32'h0);
      chk(vmon_on, 1'b0);
      vmon_below <= 1'b0;
      // sleep left by an interrupt, then by an event line
      lpm_core_model_i.wait_instr(1'b0);
      @(posedge ref_clk);
      chk({cpu_clk_en, periph_clk_en, core_pwr_en, ifo_en}, 4'h7);
      rdchk(8'h04, 32'h19);
      lpm_core_model_i.raise_irq();
      wait_on(0, 1'b1);
      rdchk(8'h08, 32'h8);
      chk(irq, 1'b1);
      lpm_core_model_i.wait_instr(1'b1);
      @(posedge ref_clk);
      chk(cpu_clk_en, 1'b0);
      lpm_core_model_i.pulse_src(0);
      wait_on(0, 1'b1);
      apb(1'b1, 8'h0c, 32'hf);
      repeat (2) @(posedge ref_clk);
      chk(irq, 1'b0);
      // standby by both select bits, then by a stop request
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, 8'h00, sb_ctrl[k]);
         lpm_core_model_i.wait_instr(k == 0);
         @(posedge ref_clk);
         chk({cpu_clk_en, periph_clk_en, core_pwr_en, ifo_en, xfo_en, sysclk_ext}, 6'h0);
         lpm_core_model_i.pulse_src(k == 0 ? 17 : EV_LINES);
         wait_on(1, 1'b1);
         chk({ifo_en, sysclk_ext}, 2'h2);
         rdchk(8'h00, sb_ctrl[k] & 32'h7f);
         rdchk(8'h08, 32'h4);
         apb(1'b1, 8'h0c, 32'hf);
      end
      // supply detector, reset pin and watchdog each end standby
      for (int s = 0; s < 3; s++) begin
         apb(1'b1, 8'h00, 32'h3);
         lpm_core_model_i.wait_instr(1'b1);
         @(posedge ref_clk);
         chk(core_pwr_en, 1'b0);
         supply_low <= (s == 0);
         ext_reset_pin_n <= (s != 1);
         wdg_reset <= (s == 2);
         wait_on(2, 1'b1);
         wait_on(1, 1'b1);
         repeat (4) @(posedge ref_clk);
         chk(system_reset, 1'b1);
         {supply_low, wdg_reset} <= 2'h0;
         ext_reset_pin_n <= 1'b1;
         wait_on(2, 1'b0);
         rdchk(8'h00, 32'h0);
      end
      complete_run();
   end
endmodule
`default_nettype wire
